// ==== core/pfpp_defines.svh ====
/*
  Constants of the parallel flash programming port: mode codes, opcodes,
  flash geometry and timing counts.
  Assumes it is included by its bare name from every file that needs it.
*/
`ifndef PFPP_DEFINES_SVH
`define PFPP_DEFINES_SVH

// capture targets selected by the mode nibble
`define PFPP_MODE_CMD      4'h0
`define PFPP_MODE_ADDRESS_BYTE0_MODE    4'h1
`define PFPP_MODE_ADDRESS_BYTE1_MODE    4'h2
`define PFPP_MODE_ADDRESS_BYTE2_MODE    4'h3
`define PFPP_MODE_ADDRESS_BYTE3_MODE    4'h4
`define PFPP_MODE_DATA     4'h5

// command opcodes on the data bus
`define PFPP_OP_READ       8'h11
`define PFPP_OP_WP         8'h12
`define PFPP_OP_WPL        8'h22
`define PFPP_OP_EWP        8'h32
`define PFPP_OP_ERASE_WRITE_PAGE_LOCK_CMD       8'h42

// flash geometry: 16 pages of 16 bytes, 4 pages per lock region
`define PFPP_PAGE_BYTES    16
`define PFPP_PAGES         16
`define PFPP_REGIONS       4
`define PFPP_OFF_MSB       3
`define PFPP_PAGE_MSB      7
`define PFPP_PAGE_LSB      4
`define PFPP_REGION_LSB    2
`define PFPP_ERASED        8'hff

// cycles spent by one page erase and program
`define PFPP_PROG_CYCLES   4'h8

`endif

// ==== core/pfpp_pkg.sv ====
/*
  Types shared by both ends of the parallel flash programming port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pfpp_pkg;

  // device end sequencer
  typedef enum logic [2:0] {
    PFPP_D_IDLE, PFPP_D_DECODE, PFPP_D_FLUSH, PFPP_D_LOAD,
    PFPP_D_WAIT_OE, PFPP_D_DRIVE, PFPP_D_VALID, PFPP_D_WAIT_STB
  } pfpp_dev_state_e;

  // programmer end sequencer
  typedef enum logic [3:0] {
    PFPP_H_IDLE, PFPP_H_SETUP, PFPP_H_WAIT_BUSY, PFPP_H_TRI, PFPP_H_WAIT_VALID,
    PFPP_H_WAIT_REL, PFPP_H_RESUME, PFPP_H_WAIT_RDY
  } pfpp_host_state_e;

endpackage

// ==== core/pfpp_if.sv ====
/*
  Pin bundle between the programmer and the device.
  Assumes both ends run on the same clock; the shared data bus is resolved
  here from the two output enables, with the pull-up seen when nobody drives.
*/
interface pfpp_if;
  logic [3:0] mode_select_pins;       // programmer-driven mode nibble
  logic [7:0] host_data;              // programmer bus drive value
  logic       host_data_oe_n;         // low while the programmer drives
  logic [7:0] dev_data;               // device bus drive value
  logic       dev_data_oe_n;          // low while the device drives
  logic [7:0] bidir_data_pins;        // resolved bus level
  logic       command_strobe_n;       // command strobe, active low
  logic       output_enable_n;        // read output enable, active low
  logic       device_ready;           // device can take a command
  logic       data_driven_n;          // low while device data is valid

  // device wins only when it drives; a clash would be a protocol fault
  assign bidir_data_pins = !dev_data_oe_n ? dev_data :
                           !host_data_oe_n ? host_data : 8'hff;

  modport dev_mp (
    input  mode_select_pins, bidir_data_pins, command_strobe_n, output_enable_n,
    output dev_data, dev_data_oe_n, device_ready, data_driven_n
  );

  modport host_mp (
    input  bidir_data_pins, device_ready, data_driven_n,
    output mode_select_pins, host_data, host_data_oe_n, command_strobe_n, output_enable_n
  );
endinterface

// ==== core/pfpp_device.sv ====
/*
  Device end of the parallel flash programming port: handshake sequencer,
  address counter, page load buffer, flash array and lock bits.
  Assumes the programmer keeps its side of the handshake and that its pins are
  synchronous to clock_i.
*/
`include "pfpp_defines.svh"

module pfpp_device (
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        sys_rst_i,
  // programming pins
  pfpp_if.dev_mp                           pins,
  // user side
  output      logic [`PFPP_REGIONS-1:0]    lock_bits_o,
  output      logic                        buffer_dirty_o
);

  pfpp_pkg::pfpp_dev_state_e state_r;      // sequencer state
  logic [3:0]  mode_cap_r;                 // captured mode nibble
  logic [7:0]  data_cap_r;                 // captured data byte
  logic [7:0]  cmd_r;                      // last accepted command
  logic        cmd_ok_r;                   // a command has been accepted
  logic [31:0] addr_r;                     // current flash address
  logic        dirty_r;                    // load buffer holds data
  logic [3:0]  buf_page_r;                 // page held in the buffer
  logic [7:0]  buf_cmd_r;                  // command that filled the buffer
  logic        load_after_r;               // flush was for a page miss
  logic [3:0]  cnt_r;                      // program timer
  logic        ready_r;                    // ready pin register
  logic        valid_n_r;                  // data-driven pin register
  logic        drive_r;                    // device owns the bus
  logic [7:0]  dout_r;                     // byte on the bus
  logic [`PFPP_REGIONS-1:0] lock_r;        // lock bit per region
  logic [7:0]  rd_col [`PFPP_PAGE_BYTES];  // addressed page, per column

  logic [3:0]  addr_page;                  // page field of the address
  logic [3:0]  addr_off;                   // byte within the page
  logic        is_read_cmd;                // read command in force
  logic        is_write_cmd;               // one of the page writes in force
  logic        page_miss;                  // write leaves the buffered page
  logic        commit;                     // buffer lands in flash now
  logic        buf_erase;                  // buffered command erases first
  logic        buf_lock;                   // buffered command locks after
  logic        strobe_low;                 // strobe seen low
  logic        enable_low;                 // output enable seen low

  assign addr_page  = addr_r[`PFPP_PAGE_MSB:`PFPP_PAGE_LSB];
  assign addr_off   = addr_r[`PFPP_OFF_MSB:0];
  assign strobe_low = !pins.command_strobe_n;
  assign enable_low = !pins.output_enable_n;

  // opcode decode; unknown opcodes leave the port a no-op until the next one
  assign is_read_cmd  = cmd_ok_r && (cmd_r == `PFPP_OP_READ);
  assign is_write_cmd = cmd_ok_r && ((cmd_r == `PFPP_OP_WP) || (cmd_r == `PFPP_OP_WPL) ||
                                     (cmd_r == `PFPP_OP_EWP) || (cmd_r == `PFPP_OP_ERASE_WRITE_PAGE_LOCK_CMD));
  assign page_miss    = dirty_r && (addr_page != buf_page_r);
  assign commit       = (state_r == pfpp_pkg::PFPP_D_FLUSH) && (cnt_r == 4'h0);
  assign buf_erase    = (buf_cmd_r == `PFPP_OP_EWP) || (buf_cmd_r == `PFPP_OP_ERASE_WRITE_PAGE_LOCK_CMD);
  assign buf_lock     = (buf_cmd_r == `PFPP_OP_WPL) || (buf_cmd_r == `PFPP_OP_ERASE_WRITE_PAGE_LOCK_CMD);

  // pins and user outputs, all from flip-flops
  assign pins.device_ready  = ready_r;
  assign pins.data_driven_n = valid_n_r;
  assign pins.dev_data_oe_n = !drive_r;
  assign pins.dev_data      = dout_r;
  assign lock_bits_o        = lock_r;
  assign buffer_dirty_o     = dirty_r;

  // sequencer: one pass per handshake, ready only returns from WAIT_STB
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r      <= pfpp_pkg::PFPP_D_IDLE;
      load_after_r <= 1'b0;
    end else begin
      unique case (state_r)
        // wait for the programmer to pull the strobe low
        pfpp_pkg::PFPP_D_IDLE: if (strobe_low) state_r <= pfpp_pkg::PFPP_D_DECODE;
        pfpp_pkg::PFPP_D_DECODE: begin
          unique case (mode_cap_r)
            `PFPP_MODE_CMD: begin
              // any new command first lands pending writes
              load_after_r <= 1'b0;
              state_r      <= dirty_r ? pfpp_pkg::PFPP_D_FLUSH : pfpp_pkg::PFPP_D_WAIT_STB;
            end
            `PFPP_MODE_DATA: begin
              if (is_read_cmd) begin
                state_r <= pfpp_pkg::PFPP_D_WAIT_OE;
              end else if (is_write_cmd && page_miss) begin
                load_after_r <= 1'b1;
                state_r      <= pfpp_pkg::PFPP_D_FLUSH;
              end else if (is_write_cmd) begin
                state_r <= pfpp_pkg::PFPP_D_LOAD;
              end else begin
                state_r <= pfpp_pkg::PFPP_D_WAIT_STB;
              end
            end
            default: begin
              // address bytes and unused codes finish at once
              state_r <= pfpp_pkg::PFPP_D_WAIT_STB;
            end
          endcase
        end
        // program timer runs out: reload the buffer on a page miss
        pfpp_pkg::PFPP_D_FLUSH: if (cnt_r == 4'h0) begin
          state_r <= load_after_r ? pfpp_pkg::PFPP_D_LOAD : pfpp_pkg::PFPP_D_WAIT_STB;
        end
        pfpp_pkg::PFPP_D_LOAD:     state_r <= pfpp_pkg::PFPP_D_WAIT_STB;
        pfpp_pkg::PFPP_D_WAIT_OE:  if (enable_low) state_r <= pfpp_pkg::PFPP_D_DRIVE;
        pfpp_pkg::PFPP_D_DRIVE:    state_r <= pfpp_pkg::PFPP_D_VALID;
        pfpp_pkg::PFPP_D_VALID:    if (!enable_low) state_r <= pfpp_pkg::PFPP_D_WAIT_STB;
        pfpp_pkg::PFPP_D_WAIT_STB: if (!strobe_low) state_r <= pfpp_pkg::PFPP_D_IDLE;
      endcase
    end
  end

  // ready: falls on capture, rises once the strobe is back high
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ready_r <= 1'b1;
    end else if (state_r == pfpp_pkg::PFPP_D_IDLE && strobe_low) begin
      ready_r <= 1'b0;
    end else if (state_r == pfpp_pkg::PFPP_D_WAIT_STB && !strobe_low) begin
      ready_r <= 1'b1;
    end
  end

  // mode and data capture on the falling strobe
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_cap_r <= 4'hf;
      data_cap_r <= 8'h00;
    end else if (state_r == pfpp_pkg::PFPP_D_IDLE && strobe_low) begin
      mode_cap_r <= pins.mode_select_pins;
      data_cap_r <= pins.bidir_data_pins;
    end
  end

  // command register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_r    <= 8'h00;
      cmd_ok_r <= 1'b0;
    end else if (state_r == pfpp_pkg::PFPP_D_DECODE && mode_cap_r == `PFPP_MODE_CMD) begin
      cmd_r    <= data_cap_r;
      cmd_ok_r <= 1'b1;
    end
  end

  // address: byte loads first to last, increment after each data byte
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_r <= 32'h0000_0000;
    end else if (state_r == pfpp_pkg::PFPP_D_DECODE) begin
      unique case (mode_cap_r)
        `PFPP_MODE_ADDRESS_BYTE0_MODE: addr_r[7:0]   <= data_cap_r;
        `PFPP_MODE_ADDRESS_BYTE1_MODE: addr_r[15:8]  <= data_cap_r;
        `PFPP_MODE_ADDRESS_BYTE2_MODE: addr_r[23:16] <= data_cap_r;
        `PFPP_MODE_ADDRESS_BYTE3_MODE: addr_r[31:24] <= data_cap_r;
        default: begin
        end
      endcase
    end else if (state_r == pfpp_pkg::PFPP_D_LOAD) begin
      addr_r <= addr_r + 32'h0000_0001;
    end else if (state_r == pfpp_pkg::PFPP_D_VALID && !enable_low) begin
      addr_r <= addr_r + 32'h0000_0001;
    end
  end

  // program timer: loaded on the way into FLUSH
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 4'h0;
    end else if (state_r == pfpp_pkg::PFPP_D_FLUSH) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      cnt_r <= `PFPP_PROG_CYCLES - 4'h1;
    end
  end

  // buffer bookkeeping; the filling command decides erase and lock later
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dirty_r    <= 1'b0;
      buf_page_r <= 4'h0;
      buf_cmd_r  <= 8'h00;
    end else if (state_r == pfpp_pkg::PFPP_D_LOAD) begin
      dirty_r    <= 1'b1;
      buf_page_r <= addr_page;
      buf_cmd_r  <= cmd_r;
    end else if (commit) begin
      dirty_r <= 1'b0;
    end
  end

  // lock bit of the programmed region, set as the flash write ends
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_r <= '0;
    end else if (commit && buf_lock) begin
      lock_r[buf_page_r[`PFPP_PAGE_MSB-`PFPP_PAGE_LSB:`PFPP_REGION_LSB]] <= 1'b1;
    end
  end

  // read bus drive: byte first, data-driven one cycle later
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drive_r   <= 1'b0;
      valid_n_r <= 1'b1;
      dout_r    <= 8'h00;
    end else if (state_r == pfpp_pkg::PFPP_D_WAIT_OE && enable_low) begin
      drive_r <= 1'b1;
      dout_r  <= rd_col[addr_off];
    end else if (state_r == pfpp_pkg::PFPP_D_DRIVE) begin
      valid_n_r <= 1'b0;
    end else if (state_r == pfpp_pkg::PFPP_D_VALID && !enable_low) begin
      drive_r   <= 1'b0;
      valid_n_r <= 1'b1;
    end
  end

  // one column per byte position: flash bytes and the load buffer byte.
  // non-erasing commands only clear bits, so a byte never loaded stays as it was; erasing ones leave it 8'hff
  for (genvar g = 0; g < `PFPP_PAGE_BYTES; g++) begin : g_col
    logic [7:0] mem_r [`PFPP_PAGES];       // this column of every page
    logic [7:0] buf_r;                     // this byte of the load buffer

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        for (int p = 0; p < `PFPP_PAGES; p++) begin
          mem_r[p] <= `PFPP_ERASED;
        end
        buf_r <= `PFPP_ERASED;
      end else if (commit) begin
        mem_r[buf_page_r] <= (buf_erase ? `PFPP_ERASED : mem_r[buf_page_r]) & buf_r;
        buf_r             <= `PFPP_ERASED;
      end else if (state_r == pfpp_pkg::PFPP_D_LOAD && addr_off == 4'(g)) begin
        buf_r <= data_cap_r;
      end
    end

    assign rd_col[g] = mem_r[addr_page];
  end

endmodule

// ==== core/pfpp_host.sv ====
/*
  Programmer end of the parallel flash programming port: runs one read or
  write handshake per user request.
  Assumes the device keeps its side of the handshake on the same clock.
*/
`include "pfpp_defines.svh"

module pfpp_host (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // programming pins
  pfpp_if.host_mp         pins,
  // user request
  input  wire logic       req_valid_i,
  input  wire logic       req_write_i,
  input  wire logic [3:0] req_mode_i,
  input  wire logic [7:0] req_data_i,
  output      logic       req_ready_o,
  // user answer
  output      logic       done_o,
  output      logic [7:0] rd_data_o
);

  pfpp_pkg::pfpp_host_state_e state_r;  // sequencer state
  logic       write_r;                  // current handshake is a write
  logic [3:0] mode_r;                   // mode nibble driven
  logic [7:0] data_r;                   // data byte driven
  logic       drive_n_r;                // bus drive enable, low drives
  logic       strobe_n_r;               // strobe pin register
  logic       oe_n_r;                   // output enable pin register
  logic       done_r;                   // end-of-handshake pulse
  logic [7:0] rd_r;                     // last byte read

  // a request is only taken while the device says ready
  assign req_ready_o           = (state_r == pfpp_pkg::PFPP_H_IDLE) && pins.device_ready;
  assign pins.mode_select_pins = mode_r;
  assign pins.host_data        = data_r;
  assign pins.host_data_oe_n   = drive_n_r;
  assign pins.command_strobe_n = strobe_n_r;
  assign pins.output_enable_n  = oe_n_r;
  assign done_o                = done_r;
  assign rd_data_o             = rd_r;

  // handshake sequencer
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= pfpp_pkg::PFPP_H_IDLE;
    end else begin
      unique case (state_r)
        pfpp_pkg::PFPP_H_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            state_r <= pfpp_pkg::PFPP_H_SETUP;
          end
        end
        // mode and data settle one cycle before the strobe falls
        pfpp_pkg::PFPP_H_SETUP: state_r <= pfpp_pkg::PFPP_H_WAIT_BUSY;
        pfpp_pkg::PFPP_H_WAIT_BUSY: begin
          if (!pins.device_ready) begin
            state_r <= write_r ? pfpp_pkg::PFPP_H_WAIT_RDY : pfpp_pkg::PFPP_H_TRI;
          end
        end
        pfpp_pkg::PFPP_H_TRI: state_r <= pfpp_pkg::PFPP_H_WAIT_VALID;
        pfpp_pkg::PFPP_H_WAIT_VALID: begin
          if (!pins.data_driven_n) begin
            state_r <= pfpp_pkg::PFPP_H_WAIT_REL;
          end
        end
        pfpp_pkg::PFPP_H_WAIT_REL: begin
          if (pins.data_driven_n) begin
            state_r <= pfpp_pkg::PFPP_H_RESUME;
          end
        end
        pfpp_pkg::PFPP_H_RESUME: state_r <= pfpp_pkg::PFPP_H_WAIT_RDY;
        pfpp_pkg::PFPP_H_WAIT_RDY: begin
          if (strobe_n_r && pins.device_ready) begin
            state_r <= pfpp_pkg::PFPP_H_IDLE;
          end
        end
        default: state_r <= pfpp_pkg::PFPP_H_IDLE;
      endcase
    end
  end

  // request capture
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      write_r <= 1'b1;
      mode_r  <= 4'hf;
      data_r  <= 8'h00;
    end else if (req_valid_i && req_ready_o) begin
      write_r <= req_write_i;
      mode_r  <= req_mode_i;
      data_r  <= req_data_i;
    end
  end

  // bus drive: off for reads between tristate and device release
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drive_n_r <= 1'b1;
    end else if (req_valid_i && req_ready_o) begin
      drive_n_r <= 1'b0;
    end else if (state_r == pfpp_pkg::PFPP_H_WAIT_BUSY && !pins.device_ready) begin
      drive_n_r <= 1'b1;
    end else if (state_r == pfpp_pkg::PFPP_H_WAIT_REL && pins.data_driven_n) begin
      drive_n_r <= 1'b0;
    end else if (state_r == pfpp_pkg::PFPP_H_WAIT_RDY && strobe_n_r && pins.device_ready) begin
      drive_n_r <= 1'b1;
    end
  end

  // strobe: falls after setup, rises once the device has gone busy on writes, after the data release on reads
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strobe_n_r <= 1'b1;
    end else if (state_r == pfpp_pkg::PFPP_H_SETUP) begin
      strobe_n_r <= 1'b0;
    end else if (state_r == pfpp_pkg::PFPP_H_WAIT_BUSY && !pins.device_ready && write_r) begin
      strobe_n_r <= 1'b1;
    end else if (state_r == pfpp_pkg::PFPP_H_RESUME) begin
      strobe_n_r <= 1'b1;
    end
  end

  // output enable and read sampling
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oe_n_r <= 1'b1;
      rd_r   <= 8'h00;
    end else if (state_r == pfpp_pkg::PFPP_H_TRI) begin
      oe_n_r <= 1'b0;
    end else if (state_r == pfpp_pkg::PFPP_H_WAIT_VALID && !pins.data_driven_n) begin
      oe_n_r <= 1'b1;
      rd_r   <= pins.bidir_data_pins;
    end
  end

  // one-cycle completion pulse
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == pfpp_pkg::PFPP_H_WAIT_RDY) && strobe_n_r && pins.device_ready;
    end
  end

endmodule

// ==== sim/pfpp_checker.sv ====
/* handshake checker for the pin bundle between both ends
   assumes one clock and the bundle signals as plain inputs */
module pfpp_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // bundle signals
  input wire logic command_strobe_n,
  input wire logic output_enable_n,
  input wire logic device_ready,
  input wire logic data_driven_n,
  input wire logic dev_data_oe_n,
  input wire logic host_data_oe_n
);
  // one domain, so clock and disable are given once
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  property p_start; $fell(command_strobe_n) |-> device_ready; endproperty
  a_start: assert property (p_start) else $error("strobe fell while busy");
  property p_tri; !output_enable_n |-> host_data_oe_n; endproperty
  a_tri: assert property (p_tri) else $error("programmer drove bus during read");
  property p_take; device_ready && !command_strobe_n |=> !device_ready; endproperty
  a_take: assert property (p_take) else $error("ready kept after strobe");
  property p_hold; !device_ready && !command_strobe_n |=> !device_ready; endproperty
  a_hold: assert property (p_hold) else $error("ready rose with strobe low");
  property p_rise; $rose(device_ready) |-> $past(command_strobe_n); endproperty
  a_rise: assert property (p_rise) else $error("ready rose early");
  property p_oe; $fell(dev_data_oe_n) |-> !$past(output_enable_n); endproperty
  a_oe: assert property (p_oe) else $error("bus driven without enable");
  property p_drive; $fell(data_driven_n) |-> !$past(dev_data_oe_n); endproperty
  a_drive: assert property (p_drive) else $error("valid before drive");
  property p_rel; !data_driven_n && output_enable_n |=> data_driven_n && dev_data_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_clash; !dev_data_oe_n |-> host_data_oe_n; endproperty
  a_clash: assert property (p_clash) else $error("both ends drive");
  property p_bound; $fell(command_strobe_n) |-> ##[1:60] $rose(device_ready); endproperty
  a_bound: assert property (p_bound) else $error("handshake never ended");
  // main scenarios: read data valid, bus turn, handshake end
  c_read: cover property ($fell(data_driven_n));
  c_turn: cover property ($fell(dev_data_oe_n));
  c_end: cover property ($rose(device_ready));
endmodule

// ==== sim/parallel_flash_programming_port_tb.sv ====
/* bench joining programmer and device ends over the pin bundle
   assumes design files and checker are compiled first */
module parallel_flash_programming_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, sys_rst_i;             // clock and reset
  logic        req_valid_i, req_write_i;       // user request
  logic [3:0]  req_mode_i, lock_bits_o;
  logic [7:0]  req_data_i, rd_data_o;
  logic        req_ready_o, done_o, buffer_dirty_o;
  int          bad_count, n_compared;
  // row: write flag, mode, data, expected read byte
  // locking commands only ever fill the last page of a region (pages 3, 7, 11)
  logic [23:0] rows [32] = '{24'h104200, 24'h113000, 24'h120000, 24'h130000, 24'h140000,
    24'h155a00, 24'h150f00, 24'h117000, 24'h157700, 24'h101200, 24'h101100, 24'h113000,
    24'h05005a, 24'h05000f, 24'h0500ff, 24'h117000, 24'h050077, 24'h102200, 24'h11b000,
    24'h150100, 24'h101100, 24'h11b000, 24'h050001, 24'h103200, 24'h113000, 24'h15c300,
    24'h101100, 24'h113000, 24'h0500c3, 24'h0500ff, 24'h170000, 24'h0500ff};
  pfpp_if pins ();
  pfpp_device i_pfpp_device (.clock_i, .sys_rst_i, .pins(pins), .lock_bits_o, .buffer_dirty_o);
  pfpp_host i_pfpp_host (.clock_i, .sys_rst_i, .pins(pins), .req_valid_i, .req_write_i,
    .req_mode_i, .req_data_i, .req_ready_o, .done_o, .rd_data_o);
  pfpp_checker i_pfpp_checker (.clock_i, .sys_rst_i, .command_strobe_n(pins.command_strobe_n),
    .output_enable_n(pins.output_enable_n), .device_ready(pins.device_ready),
    .data_driven_n(pins.data_driven_n), .dev_data_oe_n(pins.dev_data_oe_n),
    .host_data_oe_n(pins.host_data_oe_n));
  // 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic final_report();
    $display("mismatches %0d compares %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait at falling edges; a hang ends the run
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 300) begin
      @(negedge clock_i);
      k++;
    end
    if (s !== 1'b1) begin
      bad_count++;
      final_report();
    end
  endtask
  // one handshake; valid held until taken, read byte compared at done
  task automatic do_req(input logic [23:0] r);
    req_write_i = r[20];
    req_mode_i = r[19:16];
    req_data_i = r[15:8];
    req_valid_i = 1'b1;
    wait_hi(req_ready_o);
    @(negedge clock_i);
    req_valid_i = 1'b0;
    wait_hi(done_o);
    if (r[20] === 1'b0) chk(rd_data_o, r[7:0]);
    @(negedge clock_i);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_mode_i = 4'hf;
    req_data_i = 8'h00;
    repeat (20) @(negedge clock_i);
    sys_rst_i = 1'b0;
    chk({lock_bits_o, 2'h0, pins.device_ready, buffer_dirty_o}, 8'h02);
    foreach (rows[i]) do_req(rows[i]);
    chk({lock_bits_o, 3'h0, buffer_dirty_o}, 8'h70);
    do_req(24'h101200);
    do_req(24'h119000);
    do_req(24'h151100);
    chk({7'h00, buffer_dirty_o}, 8'h01);
    // second reset in mid-run clears locks and buffer
    sys_rst_i = 1'b1;
    @(negedge clock_i);
    chk({lock_bits_o, 3'h0, buffer_dirty_o}, 8'h00);
    // after release: a stray data write before any command leaves no trace
    sys_rst_i = 1'b0;
    do_req(24'h155500);
    chk({7'h00, buffer_dirty_o}, 8'h00);
    // the reset flash reads back erased where it held 8'hc3 before
    do_req(24'h101100);
    do_req(24'h113000);
    do_req(24'h0500ff);
    final_report();
  end
endmodule
